// file: design/quad_phase_fetch_pipeline.sv
// Instruction sequencing and data-memory addressing core with a two-stage pipeline
`timescale 1ns/1ps
`default_nettype none
module quad_phase_fetch_pipeline
  import quad_phase_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] prog_data,
  input wire logic [7:0] data_rdata,
  input wire logic [15:0] bank_present,
  output logic [20:0] prog_addr,
  output logic [11:0] data_addr,
  output logic data_rd,
  output logic data_wr,
  output logic [7:0] data_wdata,
  output logic phase_one,
  output logic phase_two,
  output logic phase_three,
  output logic phase_four,
  output logic [7:0] bank_pointer,
  output logic [7:0] working_reg,
  output logic zero_flag,
  output logic [20:0] program_counter
);

  // ==========================================================================
  // Phase strobes
  logic [3:0] strobe;

  phase_generator u_phase (
    .clk(clk),
    .rst_b(rst_b),
    .phase_strobe(strobe)
  );

  // Strobes already leave the generator from flops, so they feed the outputs directly
  assign phase_one = strobe[0];
  assign phase_two = strobe[1];
  assign phase_three = strobe[2];
  assign phase_four = strobe[3];

  // ==========================================================================
  // Pipeline state
  logic [20:0] pc;
  logic [15:0] fetch_word;
  logic fetch_valid;
  logic flush_fetch;
  logic [15:0] ir;
  logic ir_valid;
  logic second_pending;
  logic [7:0] first_literal;
  logic first_is_jump;
  logic skip_taken;
  logic reads_operand;
  logic [7:0] move_data;
  logic [3:0] bank;
  logic [7:0] w;
  logic [7:0] operand_value;
  logic operand_is_bank;
  logic operand_present;

  // ==========================================================================
  // Decode helpers
  // The read and write strobes ask the same question of the bank map, so it lives in one place
  function automatic logic bank_ok(input logic [15:0] present, input logic [11:0] addr);
    return present[addr[11:8]];
  endfunction

  op_t op;
  logic [11:0] mapped_addr;
  logic use_second;
  logic redirect;
  logic [20:0] redirect_target;
  logic [20:0] branch_offset;
  logic [8:0] add_sum;
  logic [7:0] result;
  logic write_needed;

  assign op = ir_valid ? decode_op(ir) : OP_NOP;
  // A second word only carries data right after its own first word
  assign use_second = (op == OP_SECOND) && second_pending;

  data_address_mapper u_map (
    .full_address(use_second || op == OP_FULL_MOVE),
    .full_addr(ir[11:0]),
    .access_banked(ir[ACCESS_BIT]),
    .bank(bank),
    .operand(ir[7:0]),
    .addr(mapped_addr)
  );

  // Counter already advanced twice when the branch executes
  assign branch_offset = word_to_byte({{9{ir[10]}}, ir[10:0]});

  // Target is formed in the execute cycle and loaded at phase four, after the wrong-path fetch
  always_comb begin
    redirect = 1'b0;
    redirect_target = pc;
    if (use_second && first_is_jump) begin
      redirect = 1'b1;
      redirect_target = word_to_byte({ir[11:0], first_literal});
    end else if (op == OP_BRANCH) begin
      redirect = 1'b1;
      redirect_target = pc - PC_STEP + branch_offset;
    end
  end

  assign add_sum = {1'b0, w} + {1'b0, operand_value};
  assign result = (op == OP_ADD_W) ? add_sum[7:0] : w;
  // Destination bit low sends the sum back to memory instead of the working register
  always_comb begin
    write_needed = 1'b0;
    if (op == OP_STORE_W) begin
      write_needed = 1'b1;
    end else if (op == OP_ADD_W) begin
      write_needed = !ir[DEST_BIT];
    end else if (use_second) begin
      write_needed = !first_is_jump;
    end
  end

  // A skip that finds zero flushes the next word just like a redirect
  assign skip_taken = (op == OP_SKIP_ZERO) && (operand_value == 8'h00);
  // Only these instructions need the operand byte; the rest leave the read strobe quiet
  assign reads_operand = (op == OP_ADD_W) || (op == OP_SKIP_ZERO) || (op == OP_FULL_MOVE);

  // ==========================================================================
  // Fetch stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc <= RESET_VECTOR;
      prog_addr <= RESET_VECTOR;
    end else if (phase_one) begin
      prog_addr <= pc;
      pc <= pc + PC_STEP;
    end else if (phase_four && redirect) begin
      // The wrong-path word fetched in this cycle is dropped through flush_fetch
      pc <= redirect_target;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_word <= NOP_WORD;
      fetch_valid <= 1'b0;
      flush_fetch <= 1'b0;
    end else if (phase_four) begin
      fetch_word <= prog_data;
      fetch_valid <= 1'b1;
      // Taken branch or successful skip turns the just-fetched word into a no-operation
      flush_fetch <= redirect || skip_taken;
    end
  end

  // ==========================================================================
  // Execute stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ir <= NOP_WORD;
      ir_valid <= 1'b0;
    end else if (phase_one) begin
      ir <= fetch_word;
      ir_valid <= fetch_valid && !flush_fetch;
    end
  end

  // Remembers the first word of a two-word instruction for its partner
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      second_pending <= 1'b0;
      first_is_jump <= 1'b0;
      first_literal <= 8'h00;
    end else if (phase_four) begin
      second_pending <= (op == OP_JUMP) || (op == OP_FULL_MOVE);
      first_is_jump <= (op == OP_JUMP);
      first_literal <= ir[7:0];
    end
  end

  // ==========================================================================
  // Data memory access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_addr <= 12'h000;
      data_rd <= 1'b0;
      operand_is_bank <= 1'b0;
      operand_present <= 1'b0;
    end else begin
      data_rd <= 1'b0;
      if (phase_two && reads_operand) begin
        data_addr <= mapped_addr;
        operand_is_bank <= (mapped_addr == BANK_POINTER_ADDR);
        operand_present <= bank_ok(bank_present, mapped_addr);
        // Missing banks get no strobe, so memory never sees the access
        data_rd <= bank_ok(bank_present, mapped_addr);
      end else if (phase_three && write_needed) begin
        data_addr <= mapped_addr;
      end
    end
  end

  // Memory answers in the same clock as the read strobe, sampled in phases three and four
  always_comb begin
    if (operand_is_bank) begin
      operand_value = {4'h0, bank};
    end else if (operand_present) begin
      operand_value = data_rdata;
    end else begin
      operand_value = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      move_data <= 8'h00;
    end else if (phase_three && op == OP_FULL_MOVE) begin
      move_data <= operand_value;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_wr <= 1'b0;
      data_wdata <= 8'h00;
    end else begin
      data_wr <= 1'b0;
      if (phase_three && write_needed && mapped_addr != BANK_POINTER_ADDR) begin
        // Writes into a missing bank are dropped on the floor
        data_wr <= bank_ok(bank_present, mapped_addr);
        data_wdata <= use_second ? move_data : result;
      end
    end
  end

  // ==========================================================================
  // Core registers
  // Load-bank never writes memory, so it cannot collide with a write to the pointer address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bank <= BANK_POINTER_RESET;
    end else if (phase_four && op == OP_LOAD_BANK) begin
      bank <= ir[3:0];
    end else if (phase_four && write_needed && mapped_addr == BANK_POINTER_ADDR) begin
      bank <= use_second ? move_data[3:0] : result[3:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w <= WORKING_RESET;
      zero_flag <= 1'b0;
    end else if (phase_four) begin
      if (op == OP_MOVE_LIT) begin
        w <= ir[7:0];
      end else if (op == OP_ADD_W) begin
        // Flag follows the sum even when the bank is missing
        zero_flag <= (add_sum[7:0] == 8'h00);
        if (ir[DEST_BIT]) begin
          w <= add_sum[7:0];
        end
      end
    end
  end

  // Visible copies lag by one clock so every output leaves a flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_pointer <= {4'h0, BANK_POINTER_RESET};
      working_reg <= WORKING_RESET;
      program_counter <= RESET_VECTOR;
    end else begin
      bank_pointer <= {4'h0, bank};
      working_reg <= w;
      program_counter <= pc;
    end
  end

endmodule
`default_nettype wire

// file: design/quad_phase_pkg.sv
// Shared constants, types and decode helpers for the quad-phase fetch pipeline
package quad_phase_pkg;

  // ==========================================================================
  // Widths, reset values and fixed addresses
  localparam logic [20:0] RESET_VECTOR = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [3:0] BANK_POINTER_RESET = 4'h0;
  localparam logic [15:0] NOP_WORD = 16'h0000;
  localparam logic [7:0] WORKING_RESET = 8'h00;
  localparam logic [11:0] BANK_POINTER_ADDR = 12'hFE0;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0] SECOND_WORD_PREFIX = 4'hF;
  localparam logic [3:0] PHASE_RESET_STROBE = 4'h1;
  localparam int ACCESS_BIT = 8;
  localparam int DEST_BIT = 9;

  // ==========================================================================
  // Instruction encodings (top bits of the first word)
  localparam logic [7:0] ENC_LOAD_BANK = 8'h01;
  localparam logic [7:0] ENC_MOVE_LIT = 8'h0E;
  localparam logic [7:0] ENC_JUMP = 8'hEF;
  localparam logic [6:0] ENC_STORE_W = 7'h37;
  localparam logic [6:0] ENC_SKIP_ZERO = 7'h33;
  localparam logic [5:0] ENC_ADD_W = 6'h09;
  localparam logic [4:0] ENC_BRANCH = 5'h1A;
  localparam logic [3:0] ENC_FULL_MOVE = 4'hC;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PHASE_ONE_S = 2'b00,
    PHASE_TWO_S = 2'b01,
    PHASE_THREE_S = 2'b11,
    PHASE_FOUR_S = 2'b10
  } phase_t;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_LOAD_BANK = 4'h1,
    OP_MOVE_LIT = 4'h2,
    OP_STORE_W = 4'h3,
    OP_ADD_W = 4'h4,
    OP_SKIP_ZERO = 4'h5,
    OP_JUMP = 4'h6,
    OP_BRANCH = 4'h7,
    OP_FULL_MOVE = 4'h8,
    OP_SECOND = 4'h9
  } op_t;

  // ==========================================================================
  // Functions
  function automatic op_t decode_op(input logic [15:0] word);
    op_t op;
    op = OP_NOP;
    if (word[15:8] == ENC_JUMP) begin
      op = OP_JUMP;
    end else if (word[15:12] == SECOND_WORD_PREFIX) begin
      op = OP_SECOND;
    end else if (word[15:12] == ENC_FULL_MOVE) begin
      op = OP_FULL_MOVE;
    end else if (word[15:11] == ENC_BRANCH) begin
      op = OP_BRANCH;
    end else if (word[15:8] == ENC_LOAD_BANK) begin
      op = OP_LOAD_BANK;
    end else if (word[15:8] == ENC_MOVE_LIT) begin
      op = OP_MOVE_LIT;
    end else if (word[15:9] == ENC_STORE_W) begin
      op = OP_STORE_W;
    end else if (word[15:9] == ENC_SKIP_ZERO) begin
      op = OP_SKIP_ZERO;
    end else if (word[15:10] == ENC_ADD_W) begin
      op = OP_ADD_W;
    end
    return op;
  endfunction

  // Word address to byte address: the low bit is always zero
  function automatic logic [20:0] word_to_byte(input logic [19:0] word_addr);
    return {word_addr, 1'b0};
  endfunction

endpackage

// file: design/phase_generator.sv
// Divide-by-four generator of four non-overlapping phase strobes
`timescale 1ns/1ps
`default_nettype none
module phase_generator
  import quad_phase_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  output logic [3:0] phase_strobe
);

  phase_t state;
  phase_t next_state;

  always_comb begin
    case (state)
      PHASE_ONE_S: next_state = PHASE_TWO_S;
      PHASE_TWO_S: next_state = PHASE_THREE_S;
      PHASE_THREE_S: next_state = PHASE_FOUR_S;
      PHASE_FOUR_S: next_state = PHASE_ONE_S;
      default: next_state = PHASE_ONE_S;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= PHASE_ONE_S;
    end else begin
      state <= next_state;
    end
  end

  // Strobes are registered from the next state so they stay glitch free
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_strobe <= PHASE_RESET_STROBE;
    end else begin
      case (next_state)
        PHASE_ONE_S: phase_strobe <= 4'h1;
        PHASE_TWO_S: phase_strobe <= 4'h2;
        PHASE_THREE_S: phase_strobe <= 4'h4;
        PHASE_FOUR_S: phase_strobe <= 4'h8;
        default: phase_strobe <= PHASE_RESET_STROBE;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: design/data_address_mapper.sv
// Forms the 12-bit data address from bank, fast window or full address
`timescale 1ns/1ps
`default_nettype none
module data_address_mapper
  import quad_phase_pkg::*;
(
  input wire logic full_address,
  input wire logic [11:0] full_addr,
  input wire logic access_banked,
  input wire logic [3:0] bank,
  input wire logic [7:0] operand,
  output logic [11:0] addr
);

  always_comb begin
    if (full_address) begin
      addr = full_addr;
    end else if (access_banked) begin
      addr = {bank, operand};
    end else if (operand < ACCESS_SPLIT) begin
      addr = {ACCESS_LOW_BANK, operand};
    end else begin
      addr = {ACCESS_HIGH_BANK, operand};
    end
  end

endmodule
`default_nettype wire

// file: verification/quad_phase_fetch_pipeline_assertions.sv
// Port-level checker for the quad-phase fetch pipeline
`timescale 1ns/1ps
`default_nettype none
module quad_phase_fetch_pipeline_checker
  import quad_phase_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] prog_data,
  input wire logic [7:0] data_rdata,
  input wire logic [15:0] bank_present,
  input wire logic [20:0] prog_addr,
  input wire logic [11:0] data_addr,
  input wire logic data_rd,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic phase_one,
  input wire logic phase_two,
  input wire logic phase_three,
  input wire logic phase_four,
  input wire logic [7:0] bank_pointer,
  input wire logic [7:0] working_reg,
  input wire logic zero_flag,
  input wire logic [20:0] program_counter
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // Phase sequencing
  sequence s_rest_of_cycle;
    phase_two ##1 phase_three ##1 phase_four ##1 phase_one;
  endsequence
  a_phase_order: assert property (phase_one |=> s_rest_of_cycle)
    else $error("phase strobes out of order");
  a_phase_onehot: assert property ($onehot({phase_one, phase_two, phase_three, phase_four}))
    else $error("phase strobes overlap");
  // ==========================================================================
  // Program side
  a_fetch_hold: assert property (!phase_one |=> $stable(prog_addr))
    else $error("fetch address moved outside phase one");
  a_fetch_even: assert property (prog_addr[0] == 1'b0 && program_counter[0] == 1'b0)
    else $error("odd program address");
  // ==========================================================================
  // Data side
  a_read_slot: assert property (data_rd |-> phase_three ##1 (!data_rd) [*3])
    else $error("operand read outside its slot");
  a_write_slot: assert property (data_wr |-> phase_four ##1 !data_wr)
    else $error("write-back outside its slot");
  a_absent_bank: assert property ((data_rd || data_wr) |-> bank_present[data_addr[11:8]])
    else $error("access strobed to a missing bank");
  a_bank_upper: assert property (bank_pointer[7:4] == 4'h0)
    else $error("bank pointer upper bits set");
endmodule
`default_nettype wire

// file: verification/mem_model.sv
// Behavioural program memory and banked data memory
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic clk,
  input wire logic [20:0] prog_addr,
  input wire logic [11:0] data_addr,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  output logic [15:0] prog_data,
  output logic [7:0] data_rdata
);
  logic [15:0] prog [0:255];
  logic [7:0] ram [0:4095];
  // Words beyond the loaded image read as no-operation
  assign prog_data = (prog_addr[20:9] == 12'h000) ? prog[prog_addr[8:1]] : 16'h0000;
  // Missing banks still return stored bytes, so zeroing is left to the core
  assign data_rdata = ram[data_addr];
  always @(posedge clk) begin
    if (data_wr) begin
      ram[data_addr] <= data_wdata;
    end
  end
endmodule
`default_nettype wire

// file: verification/tb_quad_phase_fetch_pipeline.sv
// Self-checking bench for the quad-phase fetch pipeline
`timescale 1ns/1ps
`default_nettype none
module tb_quad_phase_fetch_pipeline;
  logic clk, rst_b, data_rd, data_wr, zero_flag;
  logic phase_one, phase_two, phase_three, phase_four;
  logic [15:0] prog_data, bank_present;
  logic [7:0] data_rdata, data_wdata, bank_pointer, working_reg;
  logic [20:0] prog_addr, program_counter;
  logic [11:0] data_addr;
  int failures = 0;
  int num_checks = 0;

  quad_phase_fetch_pipeline i_quad_phase_fetch_pipeline (
    .clk(clk),
    .rst_b(rst_b),
    .prog_data(prog_data),
    .data_rdata(data_rdata),
    .bank_present(bank_present),
    .prog_addr(prog_addr),
    .data_addr(data_addr),
    .data_rd(data_rd),
    .data_wr(data_wr),
    .data_wdata(data_wdata),
    .phase_one(phase_one),
    .phase_two(phase_two),
    .phase_three(phase_three),
    .phase_four(phase_four),
    .bank_pointer(bank_pointer),
    .working_reg(working_reg),
    .zero_flag(zero_flag),
    .program_counter(program_counter)
  );
  mem_model i_mem_model (
    .clk(clk),
    .prog_addr(prog_addr),
    .data_addr(data_addr),
    .data_wr(data_wr),
    .data_wdata(data_wdata),
    .prog_data(prog_data),
    .data_rdata(data_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================================
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Flushed and skipped words would corrupt the sum or write 360h
  function automatic logic [15:0] img(input int i, input logic [7:0] lit);
    case (i)
      0: return {8'h0E, lit};
      1: return 16'h01F3;
      2: return 16'h6F10;
      3: return 16'h6E20;
      4: return 16'h6E70;
      5: return 16'h010B;
      6: return 16'h6F05;
      7: return 16'h2710;
      8: return 16'hD001;
      9: return 16'h0EFF;
      10: return 16'hEF10;
      11: return 16'hF000;
      12: return 16'h0EEE;
      16: return 16'h6640;
      17: return 16'hC310;
      18: return 16'hF360;
      19: return 16'h0103;
      20: return 16'h2710;
      21: return 16'hC310;
      22: return 16'hF350;
      23: return 16'hD7FF;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic [7:0] exp_sum(input logic [7:0] lit);
    return lit + lit;
  endfunction

  function automatic logic exp_zero(input logic [7:0] lit);
    return exp_sum(lit) == 8'h00;
  endfunction

  // ==========================================================================
  // Sequence
  initial begin
    logic [7:0] lit;
    rst_b = 1'b0;
    bank_present = 16'hFFFF;
    void'($urandom(32'h0C9C));
    for (int t = 0; t < 4; t++) begin
      lit = (t == 0) ? 8'h80 : (t == 1) ? 8'h00 : 8'($urandom);
      @(negedge clk);
      rst_b = 1'b0;
      bank_present = (16'($urandom) | 16'h8009) & 16'hF7FF;
      for (int i = 0; i < 256; i++) i_mem_model.prog[i] = img(i, lit);
      for (int i = 0; i < 4096; i++) i_mem_model.ram[i] = 8'h00;
      i_mem_model.ram[12'hB10] = 8'h33;
      i_mem_model.ram[12'hB05] = 8'h44;
      repeat (4) @(negedge clk);
      check("prog_addr in reset", prog_addr, 0);
      rst_b = 1'b1;
      #1;
      check("phase_one after release", phase_one, 1);
      @(negedge clk);
      check("phase_two after release", phase_two, 1);
      @(negedge clk);
      check("program_counter after release", program_counter, 2);
      repeat (298) @(negedge clk);
      check("working_reg", working_reg, exp_sum(lit));
      check("zero_flag", zero_flag, exp_zero(lit));
      check("bank_pointer", bank_pointer, 8'h03);
      check("ram 310", i_mem_model.ram[12'h310], lit);
      check("ram 020", i_mem_model.ram[12'h020], lit);
      check("ram F70", i_mem_model.ram[12'hF70], lit);
      check("ram B05", i_mem_model.ram[12'hB05], 8'h44);
      check("ram 350", i_mem_model.ram[12'h350], lit);
      check("ram 360", i_mem_model.ram[12'h360], 8'h00);
      $display("test %0d done literal %0h", t, lit);
    end
    end_sim();
  end

  initial begin
    repeat (2500) @(posedge clk);
    failures++;
    end_sim();
  end
endmodule

bind quad_phase_fetch_pipeline quad_phase_fetch_pipeline_checker i_quad_phase_fetch_pipeline_checker (
  .clk(clk),
  .rst_b(rst_b),
  .prog_data(prog_data),
  .data_rdata(data_rdata),
  .bank_present(bank_present),
  .prog_addr(prog_addr),
  .data_addr(data_addr),
  .data_rd(data_rd),
  .data_wr(data_wr),
  .data_wdata(data_wdata),
  .phase_one(phase_one),
  .phase_two(phase_two),
  .phase_three(phase_three),
  .phase_four(phase_four),
  .bank_pointer(bank_pointer),
  .working_reg(working_reg),
  .zero_flag(zero_flag),
  .program_counter(program_counter)
);
`default_nettype wire
